/* File: bench/spi_eeprom_protocol_engine_bench.sv */
// self-checking bench for the serial memory protocol engine
`timescale 1ns/100ps
`default_nettype none

module spi_eeprom_protocol_engine_bench;
  import spi_mem_pkg::*;

  logic clk_sys;
  logic nrst;
  logic lock_pin;
  logic sck;
  logic chip_enable_low;
  logic serial_in;
  logic pause_pin;
  logic serial_out;
  logic serial_out_en_n;
  logic [63:0] d;
  logic [7:0] s;
  int fails;
  int tests_run;

  // short write cycle keeps busy polling quick
  spi_mem_engine #(.WRITE_CYCLES(100)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .sck(sck), .chip_enable_low(chip_enable_low),
    .serial_in(serial_in), .lock_pin(lock_pin), .pause_pin(pause_pin),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n));

  spi_master_model m (
    .sck(sck), .chip_enable_low(chip_enable_low), .serial_in(serial_in),
    .pause_pin(pause_pin), .serial_out(serial_out), .serial_out_en_n(serial_out_en_n));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op);
    m.frame(8, {56'h0, op}, -1, d);
  endtask : cmd

  task automatic fetch(input int hold_at);
    m.frame(16, {48'h0, OP_FETCH, 8'h00}, hold_at, d);
    s = d[7:0];
  endtask : fetch

  task automatic store(input logic [7:0] v);
    m.frame(16, {48'h0, OP_STORE, v}, -1, d);
  endtask : store

  task automatic wr(input logic [15:0] a, input logic [15:0] v, input int n);
    m.frame(24 + 8 * n, n == 2 ? {24'h0, OP_WRITE, a, v} : {32'h0, OP_WRITE, a, v[7:0]}, -1, d);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    m.frame(40, {24'h0, OP_READ, a, 16'h0}, -1, d);
  endtask : rd

  // polls until the write cycle ends; bounded
  task automatic idle(input logic [7:0] exp);
    for (int i = 0; i < 30; i++) begin
      fetch(-1);
      if (s[ST_BUSY] === 1'b0) break;
    end
    chk(s, exp, "status after write cycle");
    if (s[ST_BUSY] !== 1'b0) close_out();
  endtask : idle

  task automatic s_arm();
    fetch(-1);
    chk(s, 8'h00, "status after reset");
    cmd(OP_ARM);
    chk(m.drv, 1'b0, "output driven in command");
    fetch(-1);
    chk(s, 8'h02, "armed");
    cmd(OP_DISARM);
    fetch(-1);
    chk(s, 8'h00, "disarmed");
    store(8'h8C);
    fetch(-1);
    chk(s, 8'h00, "store without arm");
  endtask : s_arm

  task automatic s_store_busy();
    cmd(OP_ARM);
    store(8'h0C);
    fetch(-1);
    chk(s, 8'h03, "old bits during cycle");
    idle(8'h0C);
    cmd(OP_ARM);
    store(8'h00);
    idle(8'h00);
  endtask : s_store_busy

  task automatic s_array();
    cmd(OP_ARM);
    wr(16'hFFFF, 16'h00A5, 1);
    rd(16'h7FFF);
    chk(m.drv, 1'b0, "read during cycle");
    idle(8'h00);
    cmd(OP_ARM);
    wr(16'h803F, 16'h1122, 2);
    idle(8'h00);
    rd(16'hFFFF);
    chk(d[15:0], 16'hA522, "read wraps at top");
    rd(16'h003F);
    chk(d[15:8], 8'h11, "page slot");
  endtask : s_array

  task automatic s_cancel();
    cmd(OP_ARM);
    m.frame(33, {31'h0, OP_WRITE, 16'h7FFF, 8'h99, 1'b1}, -1, d);
    fetch(-1);
    chk(s, 8'h02, "cancelled write");
    rd(16'h7FFF);
    chk(d[15:8], 8'hA5, "byte kept");
    store(8'h04);
    idle(8'h04);
    cmd(OP_ARM);
    wr(16'h7FFF, 16'h0077, 1);
    fetch(-1);
    chk(s, 8'h07, "busy on guarded write");
    idle(8'h04);
    rd(16'h7FFF);
    chk(d[15:8], 8'hA5, "guarded byte");
    cmd(OP_DISARM);
  endtask : s_cancel

  task automatic s_hard();
    cmd(OP_ARM);
    store(8'h84);
    idle(8'h84);
    lock_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmd(OP_ARM);
    store(8'h00);
    fetch(3);
    chk(s, 8'h86, "store in hard guard");
    chk(m.hold_bad, 1'b0, "output during hold");
    @(posedge clk_sys);
    lock_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    store(8'h00);
    idle(8'h00);
  endtask : s_hard

  task automatic s_unknown();
    m.frame(24, {40'h0, 8'hFF, 8'h05, 8'h00}, -1, d);
    chk(m.drv, 1'b0, "unknown instruction");
    fetch(-1);
    chk(s, 8'h00, "status after unknown");
    m.frame(16, {48'h0, OP_ARM, OP_FETCH}, -1, d);
    chk(m.drv, 1'b0, "fetch after arm in one frame");
    fetch(-1);
    chk(s, 8'h02, "armed by leading arm");
    cmd(OP_DISARM);
  endtask : s_unknown

  initial begin
    nrst = 1'b0;
    lock_pin = 1'b1;
    fails = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    s_arm();
    s_store_busy();
    s_array();
    s_cancel();
    s_hard();
    s_unknown();
    close_out();
  end
endmodule : spi_eeprom_protocol_engine_bench
`default_nettype wire

/* File: bench/spi_master_model.sv */
// serial bus master model that drives the link pins of the engine
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
  output logic      sck,
  output logic      chip_enable_low,
  output logic      serial_in,
  output logic      pause_pin,
  input  wire logic serial_out,
  input  wire logic serial_out_en_n
);
  logic drv;
  logic hold_bad;

  initial begin
    sck = 1'b0;
    chip_enable_low = 1'b1;
    serial_in = 1'b0;
    pause_pin = 1'b1;
    drv = 1'b0;
    hold_bad = 1'b0;
  end

  // clock stands low outside frames; bit n-1 goes out first
  task automatic frame(input int n, input logic [63:0] dout, input int hold_at,
                       output logic [63:0] din);
    drv = 1'b0;
    din = '0;
    chip_enable_low = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = dout[i];
      #15;
      if (i == hold_at) begin
        pause_pin = 1'b0;
        repeat (3) begin
          serial_in = ~serial_in;
          #15 sck = 1'b1;
          if (serial_out_en_n !== 1'b1) hold_bad = 1'b1;
          #15 sck = 1'b0;
        end
        pause_pin = 1'b1;
        serial_in = dout[i];
        #15;
      end
      sck = 1'b1;
      din[i] = serial_out_en_n ? 1'bz : serial_out;
      if (serial_out_en_n !== 1'b1) drv = 1'b1;
      #15 sck = 1'b0;
    end
    #15;
    // the last falling edge may still have switched the output on
    if (serial_out_en_n !== 1'b1) drv = 1'b1;
    chip_enable_low = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

/* File: src/spi_mem_engine.sv */
// serial memory protocol engine: instruction decode, status, protection, hold
// Function
// - sample on rising edge, drive on falling
// - deselected: output off, standby unless writing
// - first operation needs a select falling edge
// - lock bit clear: status write needs arm only
// - lock bit and pin low: hard guard
// - lock bit, pin high: status writable when armed
// - hard guard either order, left by pin high
// - pause with clock low freezes the link
// - deselect in pause resets protocol
// - msb first from first rising edge
// - unknown instruction: ignore rest of frame
// - 06 arms writes, 04 disarms
// - decode status fetch, store, read, write
// - writes need arm; completion clears arm
// - arm/disarm then wait for deselect
// - status fetch always allowed, repeats
// - status byte layout, latch/busy read-only
// - old nonvolatile bits until cycle ends
// - busy and latch read as live levels
// - guard bits pick protected array region
// - sixteen bit address, top bit ignored
// - status write starts on deselect after byte
// - read streams bytes, address wraps at top
// - page write wraps within 64 bytes
// - array write needs deselect at boundary
// - during write cycle reject array access
`timescale 1ns/100ps
`default_nettype none

module spi_mem_engine
  import spi_mem_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYC_DEF
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic sck,
  input  wire logic chip_enable_low,
  input  wire logic serial_in,
  input  wire logic lock_pin,
  input  wire logic pause_pin,
  output logic      serial_out,
  output logic      serial_out_en_n
);

  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       rst_link_n;
  sys_t       s;
  sys_t       next_s;
  frame_t     f;
  frame_t     next_f;
  keep_t      k;
  keep_t      next_k;
  txo_t       o;
  txo_t       next_o;
  logic [7:0] mem      [0:ARRAY_BYTES-1];
  logic [7:0] page_buf [0:PAGE_BYTES-1];
  logic       cs_rise;
  logic       arm_evt;
  logic       dis_evt;
  logic       hard;
  logic       last_tick;
  logic       active;
  logic [7:0] bit_in;
  logic [7:0] status_byte;
  logic       buf_we;
  logic       cmd_ok;

  function automatic logic guarded(input logic [1:0] bp, input logic [14:0] a);
    case (bp)
      2'h1:    guarded = &a[14:13];
      2'h2:    guarded = a[14];
      2'h3:    guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // frame logic is held in reset while deselected, and until a high select has been seen
  assign rst_link_n = ~chip_enable_low & rst_n & s.seen_high;

  // ---------------- system clock side ----------------
  assign cs_rise   = s.cs_sy[1] & ~s.cs_d;
  assign arm_evt   = s.arm_sy[1] ^ s.arm_d;
  assign dis_evt   = s.dis_sy[1] ^ s.dis_d;
  assign hard      = s.nv[2] & ~s.lock_sy[1];
  assign last_tick = s.busy && (s.cnt == CNT_W'(WRITE_CYCLES - 1));

  // kind, status value and page buffer are read here directly: they stay still while busy
  always_comb begin
    next_s         = s;
    next_s.cs_sy   = {s.cs_sy[0], chip_enable_low};
    next_s.cs_d    = s.cs_sy[1];
    next_s.lock_sy = {s.lock_sy[0], lock_pin};
    next_s.arm_sy  = {s.arm_sy[0], k.arm_tgl};
    next_s.arm_d   = s.arm_sy[1];
    next_s.dis_sy  = {s.dis_sy[0], k.dis_tgl};
    next_s.dis_d   = s.dis_sy[1];
    next_s.bnd_sy  = {s.bnd_sy[0], k.bnd};
    if (s.cs_sy[1]) begin
      next_s.seen_high = 1'b1;
    end
    if (dis_evt) begin
      next_s.latch = 1'b0;
    end
    if (s.busy) begin
      if (last_tick) begin
        next_s.busy  = 1'b0;
        next_s.cnt   = '0;
        next_s.latch = 1'b0;
        if (s.stat_cyc) begin
          next_s.nv = {k.stat[ST_LOCK], k.stat[ST_BP1], k.stat[ST_BP0]};
        end
      end else begin
        next_s.cnt = s.cnt + CNT_W'(1);
      end
    end else if (cs_rise && s.bnd_sy[1] && s.latch) begin
      if (k.kind == WK_ARRAY) begin
        next_s.busy     = 1'b1;
        next_s.stat_cyc = 1'b0;
      end else if (k.kind == WK_STATUS && !hard) begin
        next_s.busy     = 1'b1;
        next_s.stat_cyc = 1'b1;
      end
    end
    // an arm arriving with a clear still wins
    if (arm_evt) begin
      next_s.latch = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s      <= '0;
      s.nv   <= NV_RESET;
      // idle select level in the edge register; the sync stages reset low, so release still gives one false deselect edge
      s.cs_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // page commit at the end of the cycle, guarded bytes dropped
  always_ff @(posedge clk_sys) begin
    if (last_tick && !s.stat_cyc) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (k.mask[i] && !guarded(s.nv[1:0], {k.page, 6'(i)})) begin
          mem[{k.page, 6'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // ---------------- link clock side ----------------
  assign active = ~chip_enable_low & pause_pin;
  assign bit_in = {f.sh[6:0], serial_in};
  assign status_byte = {k.nv_sy[5], 3'h0, k.nv_sy[4:3], k.latch_sy[1], k.busy_sy[1]};

  always_comb begin
    next_f          = f;
    next_k          = k;
    buf_we          = 1'b0;
    cmd_ok          = 1'b0;
    next_k.busy_sy  = {k.busy_sy[0], s.busy};
    next_k.latch_sy = {k.latch_sy[0], s.latch};
    next_k.nv_sy    = {k.nv_sy[2:0], s.nv};
    if (active) begin
      next_k.bnd = 1'b0;
      next_f.sh  = bit_in;
      next_f.cnt = f.cnt + 4'h1;
      case (f.ph)
        PH_CMD: begin
          if (f.cnt[2:0] == BIT_LAST) begin
            next_f.cnt = 4'h0;
            next_f.ph  = PH_WAIT;
            cmd_ok     = 1'b1;
            case (bit_in)
              OP_ARM: begin
                next_k.arm_tgl = ~k.arm_tgl;
              end
              OP_DISARM: begin
                next_k.dis_tgl = ~k.dis_tgl;
              end
              OP_FETCH: begin
                next_f.ph = PH_STAT;
                next_f.tx = status_byte;
              end
              OP_STORE: begin
                if (!k.busy_sy[1]) begin
                  next_f.ph   = PH_SDATA;
                  next_k.kind = WK_NONE;
                end
              end
              OP_READ, OP_WRITE: begin
                if (!k.busy_sy[1]) begin
                  next_f.ph = PH_ADDR;
                  next_f.rd = (bit_in == OP_READ);
                  if (bit_in == OP_WRITE) begin
                    next_k.kind = WK_NONE;
                    next_k.mask = '0;
                  end
                end
              end
              default: begin
                cmd_ok = 1'b0;
              end
            endcase
          end
        end
        PH_ADDR: begin
          // shifting through 15 bits lets the top address bit fall away
          next_f.addr = {f.addr[13:0], serial_in};
          if (f.cnt == ADDR_LAST) begin
            next_f.cnt = 4'h0;
            if (f.rd) begin
              next_f.ph = PH_READ;
              next_f.tx = mem[{f.addr[13:0], serial_in}];
            end else begin
              next_f.ph   = PH_WDATA;
              next_k.page = f.addr[13:5];
            end
          end
        end
        PH_WDATA: begin
          if (f.cnt[2:0] == BIT_LAST) begin
            next_f.cnt       = 4'h0;
            buf_we           = 1'b1;
            next_k.mask[f.addr[5:0]] = 1'b1;
            next_f.addr[5:0] = f.addr[5:0] + 6'h01;
            next_k.kind      = WK_ARRAY;
            next_k.bnd       = 1'b1;
          end
        end
        PH_SDATA: begin
          if (f.cnt[2:0] == BIT_LAST) begin
            next_f.ph   = PH_WAIT;
            next_k.stat = bit_in;
            next_k.kind = WK_STATUS;
            next_k.bnd  = 1'b1;
          end
        end
        PH_READ: begin
          if (f.cnt[2:0] == BIT_LAST) begin
            next_f.cnt  = 4'h0;
            next_f.addr = f.addr + 15'h0001;
            next_f.tx   = mem[f.addr + 15'h0001];
          end
        end
        PH_STAT: begin
          if (f.cnt[2:0] == BIT_LAST) begin
            next_f.cnt = 4'h0;
            next_f.tx  = status_byte;
          end
        end
        default: begin
          next_f.cnt = f.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      f    <= '0;
      f.ph <= PH_CMD;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      k <= '0;
    end else begin
      k <= next_k;
    end
  end

  always_ff @(posedge sck) begin
    if (buf_we) begin
      page_buf[f.addr[5:0]] <= bit_in;
    end
  end

  always_comb begin
    next_o       = o;
    if (pause_pin) begin
      next_o.drive = (f.ph == PH_READ) || (f.ph == PH_STAT);
      next_o.so    = f.tx[BIT_LAST - f.cnt[2:0]];
    end
  end

  always_ff @(negedge sck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign serial_out      = o.so;
  // enable drops at once on deselect or pause, without waiting for a clock
  assign serial_out_en_n = ~(o.drive & pause_pin & ~chip_enable_low);

  // ---------------- checks ----------------
  busy_len_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(s.busy) |-> $past(s.cnt) == CNT_W'(WRITE_CYCLES - 1))
    else $error("write cycle ended before its full count");

  latch_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(s.busy) && !$past(arm_evt) |-> !s.latch)
    else $error("arm latch survived end of write cycle");

  arm_set_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    arm_evt |=> s.latch)
    else $error("arm command did not set latch");

  store_go_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_rise && s.bnd_sy[1] && s.latch && !s.busy && k.kind == WK_STATUS && !hard
    |=> s.busy && s.stat_cyc)
    else $error("permitted status store did not start");

  hard_block_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_rise && !s.busy && k.kind == WK_STATUS && hard |=> !s.busy)
    else $error("status store ran under hard guard");

  nv_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(s.nv) |-> $past(s.busy) && !s.busy)
    else $error("status bits changed outside cycle end");

  bad_cmd_a: assert property (
    @(posedge sck) disable iff (!rst_link_n)
    active && f.ph == PH_CMD && f.cnt[2:0] == BIT_LAST && !cmd_ok |=> f.ph == PH_WAIT)
    else $error("unknown instruction not ignored");

  read_reject_a: assert property (
    @(posedge sck) disable iff (!rst_link_n)
    active && f.ph == PH_CMD && f.cnt[2:0] == BIT_LAST && bit_in == OP_READ && k.busy_sy[1]
    |=> f.ph == PH_WAIT ##1 serial_out_en_n)
    else $error("array read accepted while busy");

  hold_freeze_a: assert property (
    @(posedge sck) disable iff (!rst_link_n)
    !pause_pin |=> $stable(f))
    else $error("frame moved during pause");

  quiet_out_a: assert property (
    @(posedge sck) disable iff (!rst_link_n)
    f.ph inside {PH_CMD, PH_ADDR, PH_WDATA, PH_SDATA, PH_WAIT} |-> serial_out_en_n)
    else $error("output driven outside data return");

endmodule : spi_mem_engine

`default_nettype wire

/* File: src/spi_mem_pkg.sv */
// constants and types shared by the serial memory protocol engine
package spi_mem_pkg;

  // system clock and self-timed write duration
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_WRITE_MS    = 10;
  localparam int unsigned WRITE_CYC_DEF = (T_WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 19;

  // array geometry
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned PAGE_BYTES  = 64;
  localparam int unsigned ARRAY_BYTES = 32768;

  // instruction codes
  localparam logic [7:0] OP_ARM    = 8'h06;
  localparam logic [7:0] OP_DISARM = 8'h04;
  localparam logic [7:0] OP_FETCH  = 8'h05;
  localparam logic [7:0] OP_STORE  = 8'h01;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_WRITE  = 8'h02;

  // protection_status field positions
  localparam int unsigned ST_LOCK = 7;
  localparam int unsigned ST_BP1  = 3;
  localparam int unsigned ST_BP0  = 2;
  localparam int unsigned ST_ARM  = 1;
  localparam int unsigned ST_BUSY = 0;

  // values after reset and bit counter end points
  localparam logic [2:0] NV_RESET  = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [3:0] ADDR_LAST = 4'hF;

  typedef enum logic [6:0] {
    PH_CMD   = 7'h01,
    PH_ADDR  = 7'h02,
    PH_WDATA = 7'h04,
    PH_SDATA = 7'h08,
    PH_READ  = 7'h10,
    PH_STAT  = 7'h20,
    PH_WAIT  = 7'h40
  } phase_t;

  typedef enum logic [1:0] {
    WK_NONE   = 2'h0,
    WK_ARRAY  = 2'h1,
    WK_STATUS = 2'h2
  } wkind_t;

  // per-frame state on the link clock, cleared while deselected
  typedef struct packed {
    phase_t      ph;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  tx;
  } frame_t;

  // link-clock state that outlives a frame
  typedef struct packed {
    wkind_t      kind;
    logic        bnd;
    logic [63:0] mask;
    logic [8:0]  page;
    logic [7:0]  stat;
    logic        arm_tgl;
    logic        dis_tgl;
    logic [1:0]  busy_sy;
    logic [1:0]  latch_sy;
    logic [5:0]  nv_sy;
  } keep_t;

  // falling-edge output stage
  typedef struct packed {
    logic so;
    logic drive;
  } txo_t;

  // system clock state
  typedef struct packed {
    logic [1:0]       cs_sy;
    logic             cs_d;
    logic [1:0]       lock_sy;
    logic             seen_high;
    logic [1:0]       arm_sy;
    logic             arm_d;
    logic [1:0]       dis_sy;
    logic             dis_d;
    logic [1:0]       bnd_sy;
    logic             latch;
    logic             busy;
    logic             stat_cyc;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       nv;
  } sys_t;

endpackage : spi_mem_pkg
